// >>> sers_master_model.sv
`timescale 1ns/10ps
module sers_master_model (
  input  wire logic ref_clk,
  input  wire logic sdaLine,
  output logic      sclPin,
  output logic      sdaLow
);
  // 16 reference clocks a bit, the nearest grid to the 125 ns link period
  initial begin
    sclPin = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // data moves only while the clock is low
  task automatic bitx(input logic b, output logic r);
    hc(3);
    sdaLow <= !b;
    hc(5);
    sclPin <= 1'b1;
    hc(4);
    r = sdaLine;
    hc(4);
    sclPin <= 1'b0;
  endtask
  task automatic start();
    hc(3);
    sdaLow <= 1'b0;
    hc(5);
    sclPin <= 1'b1;
    hc(8);
    sdaLow <= 1'b1;
    hc(8);
    sclPin <= 1'b0;
  endtask
  task automatic stop();
    hc(3);
    sdaLow <= 1'b1;
    hc(5);
    sclPin <= 1'b1;
    hc(8);
    sdaLow <= 1'b0;
    hc(8);
  endtask
  task automatic sendByte(input logic [7:0] b,
                          output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // low ack asks for the next byte, high ack ends the read
  task automatic recvByte(input logic mack,
                          output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(!mack, r);
  endtask
endmodule

// >>> sers_mem.sv
`timescale 1ns/10ps
module sers_mem
  import sers_pkg::*;
#(
  parameter int Depth = MEM_DEPTH
) (
  input  wire logic ref_clk,
  sers_mem_if.mem   memIf
);
  logic [DATA_W-1:0] store [Depth];

  // no reset on the array: contents are nonvolatile by nature
  always_ff @(posedge ref_clk) begin
    if (memIf.wrEn) begin
      store[memIf.wrAddr] <= memIf.wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    memIf.rdData <= store[memIf.rdAddr];
  end
endmodule

// >>> sers_mem_if.sv
`timescale 1ns/10ps
interface sers_mem_if;
  import sers_pkg::*;
  logic [ADDR_W-1:0] rdAddr;
  logic [DATA_W-1:0] rdData;
  logic              wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrData;
  modport ctrl (output rdAddr, output wrEn, output wrAddr, output wrData,
                input rdData);
  modport mem  (input rdAddr, input wrEn, input wrAddr, input wrData,
                output rdData);
endinterface

// >>> sers_pkg.sv
package sers_pkg;
  localparam int ADDR_W       = 11;
  localparam int DATA_W       = 8;
  localparam int MEM_DEPTH    = 2048;
  localparam int PAGE_BITS    = 4;
  // control byte field positions
  localparam int CTL_FIXED    = 7;
  localparam int CTL_SEL2     = 6;
  localparam int CTL_SEL1     = 5;
  localparam int CTL_SEL0     = 4;
  localparam int CTL_BLK_HI   = 3;
  localparam int CTL_BLK_LO   = 1;
  localparam int CTL_RW       = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [ADDR_W-1:0] PTR_RESET = 11'h000;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_NS  = 2000000;
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  // synchronised pin vector positions
  localparam int PIN_STRAP0   = 0;
  localparam int PIN_STRAP1   = 1;
  localparam int PIN_STRAP2   = 2;
  localparam int PIN_WP       = 3;
  localparam int PIN_SUPLOW   = 4;
  localparam int PIN_SCL      = 5;
  localparam int PIN_SDA      = 6;
  localparam int PIN_COUNT    = 7;

  typedef enum logic [3:0] {
    SERS_IDLE, SERS_CTRL, SERS_CTRL_ACK, SERS_ADDR, SERS_ADDR_ACK,
    SERS_WDATA, SERS_WDATA_ACK, SERS_RDATA, SERS_MACK, SERS_IGNORE
  } sers_state_t;
endpackage

// >>> sers_read_select.sv
// Functional notes
// RULE1: master loads word address with a write-type control byte then address.
// RULE2: repeated start after address abandons write, keeps loaded pointer.
// RULE3: read control byte is acknowledged, then data at pointer shifts out.
// RULE4: master no-ack then stop; device releases the data line.
// RULE5: master ack after a byte makes device send next sequential byte.
// RULE6: pointer advances by one after each completed byte operation.
// RULE7: supply-low indication blocks all erase and write activity.
// RULE8: data line driven open-drain only, low or released.
// RULE9: data changes only with clock low; high-clock edges are conditions.
// RULE10: write protect low allows reads and writes over 000-7FF.
// RULE11: write protect high inhibits all programming, reads unaffected.
// RULE12: three straps compared with select bits; respond only on match.
// RULE13: middle strap compared against the inverted control bit.
// RULE14: control byte: one, three select, three block bits, read/write.
// RULE15: no acknowledge at all while a programming cycle runs.
// RULE16: acknowledger holds data low through ninth clock high phase.
// RULE17: pointer wraps from 7FF to 000; code wraps on reads, writes roll within the 16-byte page.
`timescale 1ns/10ps
module sers_read_select
  import sers_pkg::*;
#(
  parameter int ProgCycles = PROG_CYCLES
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              sclPin,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  input  wire logic              chipSelStrap0,
  input  wire logic              chipSelStrap1Inverted,
  input  wire logic              chipSelStrap2,
  input  wire logic              writeProtect,
  input  wire logic              supplyLow,
  output logic                   progBusy,
  output logic [ADDR_W-1:0]      addrPointer
);
  sers_mem_if memIf ();

  sers_mem #(.Depth(MEM_DEPTH)) uMem (
    .ref_clk (ref_clk),
    .memIf   (memIf)
  );

  logic [PIN_COUNT-1:0] syncAQ;
  logic [PIN_COUNT-1:0] syncBQ;
  logic                 sclPrevQ;
  logic                 sdaPrevQ;
  sers_state_t          stateQ;
  logic [3:0]           bitCntQ;
  logic [DATA_W-1:0]    shiftQ;
  logic [DATA_W-1:0]    txQ;
  logic [ADDR_W-1:0]    ptrQ;
  logic                 rwQ;
  logic                 masterAckQ;
  logic                 wroteQ;
  logic                 oeQ;
  logic                 wrEnQ;
  logic [ADDR_W-1:0]    wrAddrQ;
  logic [DATA_W-1:0]    wrDataQ;
  logic                 busyQ;
  logic [31:0]          progCntQ;

  logic sclS, sdaS, sclRise, sclFall, startEv, stopEv;
  logic byteDone, ctrlMatch, writeOk;

  function automatic logic [ADDR_W-1:0] pageInc(input logic [ADDR_W-1:0] a);
    pageInc = {a[ADDR_W-1:PAGE_BITS], a[PAGE_BITS-1:0] + 4'h1};
  endfunction

  // first stage is read only by the second stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // idle bus is high; a low reset value would fake a clock fall
      syncAQ <= '1;
      syncBQ <= '1;
    end else begin
      syncAQ <= {sdaIn, sclPin, supplyLow, writeProtect, chipSelStrap2,
                 chipSelStrap1Inverted, chipSelStrap0};
      syncBQ <= syncAQ;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclPrevQ <= 1'b1;
      sdaPrevQ <= 1'b1;
    end else begin
      sclPrevQ <= sclS;
      sdaPrevQ <= sdaS;
    end
  end

  assign sclS     = syncBQ[PIN_SCL];
  assign sdaS     = syncBQ[PIN_SDA];
  assign sclRise  = sclS & ~sclPrevQ;
  assign sclFall  = ~sclS & sclPrevQ;
  // data edges with clock high are conditions, never data
  assign startEv  = sclS & sclPrevQ & sdaPrevQ & ~sdaS; // see RULE9
  assign stopEv   = sclS & sclPrevQ & ~sdaPrevQ & sdaS; // see RULE9
  assign byteDone = sclFall && (bitCntQ == BITS_PER_BYTE);
  assign ctrlMatch = shiftQ[CTL_FIXED]                          // see RULE14
                   && (shiftQ[CTL_SEL2] == syncBQ[PIN_STRAP2])  // see RULE12
                   && (shiftQ[CTL_SEL1] != syncBQ[PIN_STRAP1])  // see RULE13
                   && (shiftQ[CTL_SEL0] == syncBQ[PIN_STRAP0])  // see RULE12
                   && !busyQ;                                   // see RULE15
  assign writeOk  = !syncBQ[PIN_WP]                             // see RULE10
                  && !syncBQ[PIN_SUPLOW];                       // see RULE7

  // protocol sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stateQ     <= SERS_IDLE;
      bitCntQ    <= 4'h0;
      shiftQ     <= '0;
      txQ        <= '0;
      rwQ        <= 1'b0;
      masterAckQ <= 1'b0;
      oeQ        <= 1'b0;
    end else if (startEv) begin
      // repeated start drops a partly shifted byte but keeps the pointer; bytes already completed stay written
      stateQ  <= SERS_CTRL; // see RULE2
      bitCntQ <= 4'h0;
      oeQ     <= 1'b0;
    end else if (stopEv) begin
      stateQ  <= SERS_IDLE;
      oeQ     <= 1'b0; // see RULE4
    end else begin
      case (stateQ)
        SERS_CTRL, SERS_ADDR, SERS_WDATA: begin
          if (sclRise) begin
            shiftQ  <= {shiftQ[DATA_W-2:0], sdaS};
            bitCntQ <= bitCntQ + 4'h1;
          end else if (byteDone) begin
            bitCntQ <= 4'h0;
            if (stateQ == SERS_CTRL) begin
              if (ctrlMatch) begin
                rwQ    <= shiftQ[CTL_RW];
                oeQ    <= 1'b1; // see RULE16
                stateQ <= SERS_CTRL_ACK;
              end else begin
                stateQ <= SERS_IGNORE; // see RULE12
              end
            end else begin
              oeQ    <= 1'b1; // see RULE16
              stateQ <= (stateQ == SERS_ADDR) ? SERS_ADDR_ACK
                                              : SERS_WDATA_ACK;
            end
          end
        end
        SERS_CTRL_ACK: begin
          if (sclFall) begin
            if (rwQ) begin
              // first data bit goes out on the same falling edge
              txQ    <= memIf.rdData; // see RULE3
              oeQ    <= ~memIf.rdData[DATA_W-1]; // see RULE8
              stateQ <= SERS_RDATA;
            end else begin
              oeQ    <= 1'b0;
              stateQ <= SERS_ADDR; // see RULE1
            end
          end
        end
        SERS_ADDR_ACK, SERS_WDATA_ACK: begin
          if (sclFall) begin
            oeQ    <= 1'b0;
            stateQ <= SERS_WDATA;
          end
        end
        SERS_RDATA: begin
          if (sclRise) begin
            bitCntQ <= bitCntQ + 4'h1;
          end else if (byteDone) begin
            bitCntQ <= 4'h0;
            oeQ     <= 1'b0;
            stateQ  <= SERS_MACK;
          end else if (sclFall) begin
            txQ <= {txQ[DATA_W-2:0], 1'b0};
            oeQ <= ~txQ[DATA_W-2]; // see RULE8
          end
        end
        SERS_MACK: begin
          if (sclRise) begin
            masterAckQ <= ~sdaS;
          end else if (sclFall) begin
            if (masterAckQ) begin
              txQ    <= memIf.rdData; // see RULE5
              oeQ    <= ~memIf.rdData[DATA_W-1];
              stateQ <= SERS_RDATA;
            end else begin
              stateQ <= SERS_IGNORE; // see RULE4
            end
          end
        end
        SERS_IDLE, SERS_IGNORE: begin
          oeQ <= 1'b0;
        end
        default: begin
          stateQ <= SERS_IDLE;
          oeQ    <= 1'b0;
        end
      endcase
    end
  end

  // address pointer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ptrQ <= PTR_RESET;
    end else if (byteDone && stateQ == SERS_CTRL && ctrlMatch) begin
      ptrQ[ADDR_W-1:DATA_W] <= shiftQ[CTL_BLK_HI:CTL_BLK_LO]; // see RULE14
    end else if (byteDone && stateQ == SERS_ADDR) begin
      ptrQ[DATA_W-1:0] <= shiftQ; // see RULE1
    end else if (byteDone && stateQ == SERS_WDATA) begin
      // writes roll within the page, as the page buffer does
      ptrQ <= pageInc(ptrQ); // see RULE6
    end else if (byteDone && stateQ == SERS_RDATA) begin
      // 11-bit add wraps 7FF to 000
      ptrQ <= ptrQ + 11'h001; // see RULE6, see RULE17
    end
  end

  // memory write port; protection gates the strobe itself
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrEnQ   <= 1'b0;
      wrAddrQ <= '0;
      wrDataQ <= '0;
    end else begin
      wrEnQ   <= byteDone && stateQ == SERS_WDATA && writeOk; // see RULE11
      wrAddrQ <= ptrQ;
      wrDataQ <= shiftQ;
    end
  end

  assign memIf.rdAddr = ptrQ;
  assign memIf.wrEn   = wrEnQ;
  assign memIf.wrAddr = wrAddrQ;
  assign memIf.wrData = wrDataQ;

  // programming cycle: starts at stop after an accepted write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wroteQ   <= 1'b0;
      busyQ    <= 1'b0;
      progCntQ <= '0;
    end else begin
      if (wrEnQ) begin
        wroteQ <= 1'b1;
      end else if (stopEv || startEv) begin
        wroteQ <= 1'b0;
      end
      if (stopEv && wroteQ && !syncBQ[PIN_SUPLOW]) begin // see RULE7
        busyQ    <= 1'b1;
        progCntQ <= 32'(ProgCycles - 1);
      end else if (busyQ) begin
        if (progCntQ == '0) begin
          busyQ <= 1'b0;
        end else begin
          progCntQ <= progCntQ - 32'd1;
        end
      end
    end
  end

  // open drain: data pin level is never driven high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0; // see RULE8
    end
  end

  assign sdaOe       = oeQ;
  assign progBusy    = busyQ;
  assign addrPointer = ptrQ;

  logic inAck;
  assign inAck = (stateQ == SERS_CTRL_ACK) || (stateQ == SERS_ADDR_ACK)
              || (stateQ == SERS_WDATA_ACK);

  a_pin_never_high: assert property ( // see RULE8
    @(posedge ref_clk) disable iff (!rst_n)
    sdaOe |-> !sdaOut && (inAck || stateQ == SERS_RDATA))
    else $error("data pin driven high");
  a_busy_no_ack: assert property ( // see RULE15
    @(posedge ref_clk) disable iff (!rst_n)
    (stateQ == SERS_CTRL_ACK) |-> !busyQ)
    else $error("acknowledge while programming");
  a_protect_no_write: assert property ( // see RULE11
    @(posedge ref_clk) disable iff (!rst_n)
    $past(syncBQ[PIN_WP]) |-> !wrEnQ)
    else $error("write while protected");
  a_supply_no_write: assert property ( // see RULE7
    @(posedge ref_clk) disable iff (!rst_n)
    $past(syncBQ[PIN_SUPLOW]) |-> !wrEnQ)
    else $error("write while supply low");
  a_read_ptr_step: assert property ( // see RULE6
    @(posedge ref_clk) disable iff (!rst_n)
    (byteDone && stateQ == SERS_RDATA && !startEv && !stopEv)
    |=> ptrQ == 11'($past(ptrQ) + 11'h001))
    else $error("pointer did not advance");
  a_stop_release: assert property ( // see RULE4
    @(posedge ref_clk) disable iff (!rst_n)
    stopEv |=> !sdaOe ##1 !sdaOe)
    else $error("line held after stop");
  a_ack_hold_high: assert property ( // see RULE16
    @(posedge ref_clk) disable iff (!rst_n)
    (inAck && sdaOe && sclS && !sclFall && !startEv && !stopEv) |=> sdaOe)
    else $error("ack dropped in clock high");
  a_oe_clock_low: assert property ( // see RULE9
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(sdaOe) |-> !sclS || $past(startEv) || $past(stopEv))
    else $error("data changed with clock high");
  a_select_miss: assert property ( // see RULE12, see RULE13
    @(posedge ref_clk) disable iff (!rst_n)
    (byteDone && stateQ == SERS_CTRL && !ctrlMatch && !startEv && !stopEv)
    |=> stateQ == SERS_IGNORE ##1 !sdaOe)
    else $error("responded without select match");
  a_addr_load: assert property ( // see RULE1, see RULE2
    @(posedge ref_clk) disable iff (!rst_n)
    (byteDone && stateQ == SERS_ADDR && !startEv && !stopEv)
    |=> ptrQ[DATA_W-1:0] == $past(shiftQ))
    else $error("word address not loaded");
  a_write_allowed: assert property ( // see RULE10
    @(posedge ref_clk) disable iff (!rst_n)
    (byteDone && stateQ == SERS_WDATA && writeOk && !startEv && !stopEv)
    |=> wrEnQ)
    else $error("allowed write lost");
endmodule

// >>> sers_read_select_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, e); \
  end \
end
module sers_read_select_tb_top;
  import sers_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              strap0 = 1'b1;
  logic              strap1Inv = 1'b0;
  logic              strap2 = 1'b1;
  logic              wp = 1'b0;
  logic              supLow = 1'b0;
  logic              sclPin;
  logic              sdaLow;
  logic              sdaOut;
  logic              sdaOe;
  logic              progBusy;
  logic [ADDR_W-1:0] addrPointer;
  wire               sdaLine = !(sdaOe || sdaLow);
  int                bad_count = 0;
  int                comparisons = 0;
  logic              ack;
  logic [7:0]        rd;

  initial begin
    forever #4 ref_clk = !ref_clk;
  end

  sers_read_select #(.ProgCycles(400)) i_sers_read_select (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclPin(sclPin), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelStrap0(strap0),
    .chipSelStrap1Inverted(strap1Inv), .chipSelStrap2(strap2),
    .writeProtect(wp), .supplyLow(supLow), .progBusy(progBusy),
    .addrPointer(addrPointer));
  sers_master_model i_sers_master_model (
    .ref_clk(ref_clk), .sdaLine(sdaLine), .sclPin(sclPin),
    .sdaLow(sdaLow));

  always @(posedge ref_clk) begin
    if (sdaOe === 1'b1) `CHK(sdaOut, 1'b0)
  end

  function automatic logic [7:0] ctl(logic [2:0] blk, logic rw);
    return {1'b1, strap2, ~strap1Inv, strap0, blk, rw};
  endfunction
  task automatic hc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic write_seq(input logic [10:0] a, input logic [15:0] d,
                           input int n);
    i_sers_master_model.start();
    i_sers_master_model.sendByte(ctl(a[10:8], 1'b0), ack);
    `CHK(ack, 1'b1)
    i_sers_master_model.sendByte(a[7:0], ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      i_sers_master_model.sendByte(d[15-8*i -: 8], ack);
      `CHK(ack, 1'b1)
    end
    i_sers_master_model.stop();
  endtask
  task automatic read_seq(input logic [10:0] a, input logic [23:0] e,
                          input int n);
    i_sers_master_model.start();
    i_sers_master_model.sendByte(ctl(a[10:8], 1'b0), ack);
    i_sers_master_model.sendByte(a[7:0], ack);
    i_sers_master_model.start();
    i_sers_master_model.sendByte(ctl(a[10:8], 1'b1), ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      i_sers_master_model.recvByte(i < n - 1, rd);
      `CHK(rd, e[23-8*i -: 8])
    end
    i_sers_master_model.stop();
    hc(4);
    `CHK(sdaOe, 1'b0)
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (progBusy !== 1'b0 && k < 2000) begin
      hc(1);
      k++;
    end
    `CHK(progBusy, 1'b0)
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    hc(40000);
    bad_count++;
    $display("[ERR] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    wrap_up();
  end

  initial begin
    hc(10);
    rst_n <= 1'b1;
    `CHK(addrPointer, PTR_RESET)
    `CHK(sdaOe, 1'b0)
    hc(3);
    write_seq(11'h7FF, 16'hA500, 1);
    hc(2);
    `CHK(progBusy, 1'b1)
    // busy array: even our own control byte goes unanswered
    i_sers_master_model.start();
    i_sers_master_model.sendByte(ctl(3'h0, 1'b0), ack);
    `CHK(ack, 1'b0)
    i_sers_master_model.stop();
    wait_idle();
    write_seq(11'h000, 16'h3C96, 2);
    wait_idle();
    $display("write test done");
    read_seq(11'h7FF, 24'hA53C96, 3);
    `CHK(addrPointer, 11'h002)
    $display("sequential read test done");
    for (int k = 0; k < 2; k++) begin
      wp <= (k == 0);
      supLow <= (k == 1);
      hc(4);
      write_seq(11'h001, 16'h0000, 1);
      hc(8);
      wait_idle();
      wp <= 1'b0;
      supLow <= 1'b0;
      hc(4);
      read_seq(11'h001, 24'h960000, 1);
    end
    $display("protection test done");
    strap2 <= 1'b0;
    strap1Inv <= 1'b1;
    strap0 <= 1'b0;
    hc(4);
    for (int b = 4; b < 8; b++) begin
      i_sers_master_model.start();
      i_sers_master_model.sendByte(ctl(3'h0, 1'b1) ^ (8'h01 << b), ack);
      `CHK(ack, 1'b0)
      i_sers_master_model.stop();
    end
    i_sers_master_model.start();
    i_sers_master_model.sendByte(ctl(3'h0, 1'b0), ack);
    i_sers_master_model.sendByte(8'h01, ack);
    i_sers_master_model.start();
    i_sers_master_model.sendByte(ctl(3'h0, 1'b1), ack);
    `CHK(ack, 1'b1)
    i_sers_master_model.recvByte(1'b0, rd);
    `CHK(rd, 8'h96)
    i_sers_master_model.stop();
    $display("select test done");
    wrap_up();
  end
endmodule
